// File: fbs_defines.vh
`ifndef FBS_DEFINES_VH
`define FBS_DEFINES_VH

`define FBS_BLOCK_BYTES 64
`define FBS_IDX_W 6
`define FBS_PTR_W 22
`define FBS_BLK_HI 21
`define FBS_BLK_LO 6
`define FBS_BLK_W 16
`define FBS_ERASED_BYTE 8'hff
`define FBS_UNLOCK_KEY1 8'h55
`define FBS_UNLOCK_KEY2 8'haa
`define FBS_CLK_HZ 10000000
`define FBS_LONG_WRITE_US 2000
`define FBS_TMR_W 16

`endif

// File: fbs_hold_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "fbs_defines.vh"

// ************************************************************
// Holding register bank: 64 bytes loaded by table writes.
// ************************************************************
module fbs_hold_regs (
   input wire clk_sys,
   input wire rst,
   input wire wr_en,
   input wire [`FBS_IDX_W-1:0] wr_idx,
   input wire [7:0] wr_data,
   input wire preset_all,
   input wire [`FBS_IDX_W-1:0] rd_idx,
   output wire [7:0] rd_data
);
   reg [7:0] hold_ff [0:`FBS_BLOCK_BYTES-1];
   integer i;

   always @(posedge clk_sys) begin
      if (rst || preset_all) begin
         for (i = 0; i < `FBS_BLOCK_BYTES; i = i + 1) begin
            hold_ff[i] <= `FBS_ERASED_BYTE;
         end
      end else if (wr_en) begin
         hold_ff[wr_idx] <= wr_data;
      end
   end

   assign rd_data = hold_ff[rd_idx];
endmodule
`default_nettype wire

// File: fbs_seq.v
// Summary of operation
// - Erase only whole 64-byte blocks, never words.
// - Erase block chosen by pointer bits 21..6.
// - Valid erase start erases block, stalls 2 ms.
// - CPU halted for whole long write cycle.
// - Program only whole 64-byte blocks.
// - 64 holding bytes; table writes touch only them.
// - After loading and unlock, block goes to flash.
// - Internal timer ends long write without software.
// - Holding bytes become FFh on reset, after writes.
// - Holding byte FFh leaves flash byte unchanged.
// - Software cannot erase more than one block.
// - Start bit set-only, hardware clears at completion.
// - Erase select cleared when erase completes.
// - Abort flag on reset-interrupted or improper write.
// - Table write selects byte by pointer low bits.
`timescale 1ns/1ps
`default_nettype none
`include "fbs_defines.vh"

module fbs_seq (
   input wire clk_sys,
   input wire rst,
   input wire [`FBS_PTR_W-1:0] table_pointer,
   input wire [7:0] table_latch,
   input wire table_write_op,
   input wire unlock_wr,
   input wire [7:0] unlock_data,
   input wire ctrl_wr,
   input wire program_space_select_in,
   input wire config_space_select_in,
   input wire write_allow_bit_in,
   input wire erase_select_in,
   input wire start_set,
   input wire abort_clear,
   output reg program_space_select,
   output reg config_space_select,
   output reg write_allow_bit,
   output reg erase_select,
   output reg start_bit,
   output reg write_abort_flag,
   output wire cpu_stall,
   output reg flash_erase,
   output reg flash_prog,
   output reg [`FBS_BLK_W-1:0] flash_block,
   output reg [`FBS_IDX_W-1:0] flash_idx,
   output reg [7:0] flash_data,
   output reg flash_byte_en
);
   // ************************************************************
   // Timing.
   // ************************************************************
   localparam integer LONG_WRITE_INT = (`FBS_CLK_HZ / 1000000) * `FBS_LONG_WRITE_US;
   localparam [`FBS_TMR_W-1:0] LONG_WRITE_CYC = LONG_WRITE_INT[`FBS_TMR_W-1:0];
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_ERASE = 2'b01;
   localparam [1:0] ST_PROG = 2'b10;
   localparam [1:0] UL_NONE = 2'b00;
   localparam [1:0] UL_KEY1 = 2'b01;
   localparam [1:0] UL_ARMED = 2'b10;

   reg [1:0] state_ff;
   reg [1:0] unlock_ff;
   reg [`FBS_TMR_W-1:0] tmr_ff;
   reg [`FBS_IDX_W-1:0] scan_ff;
   reg scan_end_ff;
   reg preset_ff;
   reg rst_seen_ff;
   wire [7:0] hold_byte;
   wire busy;
   wire tmr_done;
   wire setup_ok;

   function is_erased;
      input [7:0] b;
      begin
         is_erased = (b == `FBS_ERASED_BYTE);
      end
   endfunction

   assign busy = (state_ff != ST_IDLE);
   assign cpu_stall = busy;
   assign tmr_done = (tmr_ff == {`FBS_TMR_W{1'b0}});
   assign setup_ok = program_space_select && !config_space_select && write_allow_bit;

   // ************************************************************
   // Holding registers.
   // ************************************************************
   fbs_hold_regs u_hold (
      .clk_sys(clk_sys),
      .rst(rst),
      .wr_en(table_write_op && !busy),
      .wr_idx(table_pointer[`FBS_IDX_W-1:0]),
      .wr_data(table_latch),
      .preset_all(preset_ff),
      .rd_idx(scan_ff),
      .rd_data(hold_byte)
   );

   // ************************************************************
   // Unlock tracker.
   // ************************************************************
   always @(posedge clk_sys) begin
      if (rst) begin
         unlock_ff <= UL_NONE;
      end else if (unlock_wr) begin
         if (unlock_data == `FBS_UNLOCK_KEY1) begin
            unlock_ff <= UL_KEY1;
         end else if (unlock_data == `FBS_UNLOCK_KEY2 && unlock_ff == UL_KEY1) begin
            unlock_ff <= UL_ARMED;
         end else begin
            unlock_ff <= UL_NONE;
         end
      end else if (start_set || ctrl_wr || table_write_op) begin
         unlock_ff <= UL_NONE;
      end
   end

   // ************************************************************
   // Control bits and sequencer.
   // ************************************************************
   always @(posedge clk_sys) begin
      if (rst) begin
         state_ff <= ST_IDLE;
         tmr_ff <= {`FBS_TMR_W{1'b0}};
         scan_ff <= {`FBS_IDX_W{1'b0}};
         scan_end_ff <= 1'b0;
         preset_ff <= 1'b0;
         write_allow_bit <= 1'b0;
         erase_select <= 1'b0;
         start_bit <= 1'b0;
         flash_erase <= 1'b0;
         flash_prog <= 1'b0;
         flash_block <= {`FBS_BLK_W{1'b0}};
         flash_idx <= {`FBS_IDX_W{1'b0}};
         flash_data <= `FBS_ERASED_BYTE;
         flash_byte_en <= 1'b0;
      end else begin
         preset_ff <= 1'b0;
         flash_erase <= 1'b0;
         flash_prog <= 1'b0;
         if (ctrl_wr && !busy) begin
            write_allow_bit <= write_allow_bit_in;
            erase_select <= erase_select_in;
         end
         case (state_ff)
            ST_IDLE: begin
               if (start_set && unlock_ff == UL_ARMED && setup_ok) begin
                  start_bit <= 1'b1;
                  tmr_ff <= LONG_WRITE_CYC;
                  flash_block <= table_pointer[`FBS_BLK_HI:`FBS_BLK_LO];
                  scan_ff <= {`FBS_IDX_W{1'b0}};
                  scan_end_ff <= 1'b0;
                  if (erase_select) begin
                     state_ff <= ST_ERASE;
                     flash_erase <= 1'b1;
                  end else begin
                     state_ff <= ST_PROG;
                  end
               end
            end
            ST_ERASE: begin
               tmr_ff <= tmr_ff - 1'b1;
               if (tmr_done) begin
                  state_ff <= ST_IDLE;
                  start_bit <= 1'b0;
                  erase_select <= 1'b0;
                  preset_ff <= 1'b1;
               end
            end
            ST_PROG: begin
               tmr_ff <= tmr_ff - 1'b1;
               // Each holding byte is offered once; the end flag stops a second pass.
               if (!scan_end_ff) begin
                  flash_prog <= 1'b1;
                  flash_idx <= scan_ff;
                  flash_data <= hold_byte;
                  flash_byte_en <= !is_erased(hold_byte);
                  scan_ff <= scan_ff + 1'b1;
                  if (&scan_ff) begin
                     scan_end_ff <= 1'b1;
                  end
               end else begin
                  flash_byte_en <= 1'b0;
               end
               if (tmr_done) begin
                  state_ff <= ST_IDLE;
                  start_bit <= 1'b0;
                  preset_ff <= 1'b1;
                  flash_prog <= 1'b0;
                  flash_byte_en <= 1'b0;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // Space selects and abort flag are not cleared by reset; reset during a write sets the abort flag.
   // ************************************************************
   always @(posedge clk_sys) begin
      rst_seen_ff <= busy && rst;
      if (ctrl_wr && !busy && !rst) begin
         program_space_select <= program_space_select_in;
         config_space_select <= config_space_select_in;
      end
      if (rst_seen_ff || (rst && busy)) begin
         write_abort_flag <= 1'b1;
      end else if (!rst && start_set && !(unlock_ff == UL_ARMED && setup_ok) && !busy) begin
         write_abort_flag <= 1'b1;
      end else if (!rst && abort_clear) begin
         write_abort_flag <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// File: fbs_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Sequencer port checks.
// ****************
module fbs_checker (
   input wire clk_sys,
   input wire rst,
   input wire unlock_wr,
   input wire [7:0] unlock_data,
   input wire start_set,
   input wire program_space_select,
   input wire config_space_select,
   input wire write_allow_bit,
   input wire erase_select,
   input wire start_bit,
   input wire write_abort_flag,
   input wire cpu_stall,
   input wire flash_erase,
   input wire flash_prog,
   input wire [7:0] flash_data,
   input wire flash_byte_en
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   reg [15:0] cnt_ff;
   always @(posedge clk_sys) cnt_ff <= (rst || !cpu_stall) ? 16'h0 : cnt_ff + 16'h1;
   sequence keys_s;
      unlock_wr && unlock_data == 8'h55 ##1 unlock_wr && unlock_data == 8'haa;
   endsequence
   start_ok_a: assert property (keys_s ##1 start_set && !start_bit && program_space_select &&
      !config_space_select && write_allow_bit |=> start_bit) else $error("start refused");
   key_seen_a: assert property ($rose(start_bit) |-> $past(start_set) &&
      $past(unlock_wr, 2) && $past(unlock_data, 2) == 8'haa) else $error("start without key");
   stall_tie_a: assert property (cpu_stall == start_bit) else $error("stall mismatch");
   stall_len_a: assert property ($fell(cpu_stall) |-> cnt_ff == 16'h4e21) else $error("len");
   stall_max_a: assert property (cpu_stall |-> cnt_ff < 16'h4e21) else $error("stall long");
   erase_go_a: assert property ($rose(start_bit) && erase_select |-> flash_erase)
      else $error("no erase");
   erase_one_a: assert property (flash_erase |=> !flash_erase) else $error("erase twice");
   erase_clr_a: assert property ($fell(start_bit) |-> !erase_select) else $error("sel kept");
   ff_skip_a: assert property (flash_prog |-> flash_byte_en == (flash_data != 8'hff) &&
      cpu_stall) else $error("byte enable");
   abort_set_a: assert property (start_set && !start_bit && !$past(unlock_wr) |=>
      write_abort_flag) else $error("abort flag");
endmodule
bind fbs_seq fbs_checker u_fbs_checker (.clk_sys(clk_sys), .rst(rst), .unlock_wr(unlock_wr),
   .unlock_data(unlock_data), .start_set(start_set), .start_bit(start_bit),
   .program_space_select(program_space_select), .config_space_select(config_space_select),
   .write_allow_bit(write_allow_bit), .erase_select(erase_select), .cpu_stall(cpu_stall),
   .write_abort_flag(write_abort_flag), .flash_erase(flash_erase), .flash_prog(flash_prog),
   .flash_data(flash_data), .flash_byte_en(flash_byte_en));
`default_nettype wire

// File: fbs_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// One-block flash array model.
// ****************
module fbs_flash_model (
   input wire clk_sys,
   input wire flash_erase,
   input wire flash_prog,
   input wire [15:0] flash_block,
   input wire [5:0] flash_idx,
   input wire [7:0] flash_data,
   input wire flash_byte_en
);
   reg [7:0] mem [0:63];
   reg [15:0] blk;
   integer n_prog = 0;
   integer n_en = 0;
   integer k;
   always @(posedge clk_sys) begin
      if (flash_erase) begin
         blk <= flash_block;
         for (k = 0; k < 64; k = k + 1) mem[k] <= 8'hff;
      end
      if (flash_prog) n_prog <= n_prog + 1;
      if (flash_prog && flash_byte_en) begin
         n_en <= n_en + 1;
         mem[flash_idx] <= mem[flash_idx] & flash_data;
      end
   end
endmodule
`default_nettype wire

// File: fbs_seq_test.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Sequencer testbench.
// ****************
module fbs_seq_test;
   reg clk_sys = 1'b0;
   reg rst = 1'b1;
   reg [21:0] ptr = 22'h0;
   reg [7:0] lat = 8'h0, key = 8'h0;
   reg twr = 1'b0, uwr = 1'b0, cwr = 1'b0, sset = 1'b0, aclr = 1'b0;
   reg [3:0] cin = 4'h0;
   wire psel, csel, wal, esel, sbit, abrt, stall, fer, fpr, fen;
   wire [15:0] fblk;
   wire [5:0] fidx;
   wire [7:0] fdat;
   integer n_mismatch = 0, cmp_count = 0, i;
   always #50 clk_sys = ~clk_sys;
   fbs_seq u_fbs_seq (.clk_sys(clk_sys), .rst(rst), .table_pointer(ptr), .table_latch(lat),
      .table_write_op(twr), .unlock_wr(uwr), .unlock_data(key), .ctrl_wr(cwr),
      .program_space_select_in(cin[3]), .config_space_select_in(cin[2]),
      .write_allow_bit_in(cin[1]), .erase_select_in(cin[0]), .start_set(sset),
      .abort_clear(aclr), .program_space_select(psel), .config_space_select(csel),
      .write_allow_bit(wal), .erase_select(esel), .start_bit(sbit), .write_abort_flag(abrt),
      .cpu_stall(stall), .flash_erase(fer), .flash_prog(fpr), .flash_block(fblk),
      .flash_idx(fidx), .flash_data(fdat), .flash_byte_en(fen));
   fbs_flash_model u_fbs_flash_model (.clk_sys(clk_sys), .flash_erase(fer), .flash_prog(fpr),
      .flash_block(fblk), .flash_idx(fidx), .flash_data(fdat), .flash_byte_en(fen));
   task chk(input string name, input [15:0] e, input [15:0] g);
      begin
         cmp_count = cmp_count + 1;
         if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value %s expected %h seen %h", name, e, g);
         end
      end
   endtask
   task conclude;
      begin
         $display("%0d comparisons, %0d mismatches", cmp_count, n_mismatch);
         if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
         else $display("TEST FAILED");
         $finish;
      end
   endtask
   task pulse_ctl(input [3:0] v);
      begin
         @(posedge clk_sys);
         cwr <= 1'b1;
         cin <= v;
         @(posedge clk_sys);
         cwr <= 1'b0;
      end
   endtask
   task go(input [7:0] k1, input [7:0] k2, input u);
      begin
         @(posedge clk_sys);
         uwr <= u;
         key <= k1;
         @(posedge clk_sys);
         key <= k2;
         @(posedge clk_sys);
         uwr <= 1'b0;
         sset <= 1'b1;
         @(posedge clk_sys);
         sset <= 1'b0;
         #1;
      end
   endtask
   task done_wait;
      integer w;
      begin
         for (w = 0; w < 30000 && stall !== 1'b0; w = w + 1) @(posedge clk_sys);
         #1;
         chk("busy", 16'h0, {sbit, stall});
      end
   endtask
   initial begin
      #(100 * 90000);
      n_mismatch = n_mismatch + 1;
      conclude;
   end
   initial begin
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      #1;
      chk("idle", 16'h0, {sbit, stall, esel});
      ptr <= 22'h2a5b3;
      pulse_ctl(4'hb);
      go(8'h55, 8'haa, 1'b1);
      chk("erase start", 16'h3, {sbit, stall});
      done_wait;
      chk("erase block", ptr[21:6], u_fbs_flash_model.blk);
      chk("erase select", 16'h0, esel);
      $display("test erase done");
      for (i = 0; i < 64; i = i + 1)
         tw({i[15:0] ^ 16'h5a5a, i[5:0]}, (i % 3 == 0) ? 8'hff : i[7:0] ^ 8'hc3);
      pulse_ctl(4'ha);
      go(8'h55, 8'haa, 1'b1);
      chk("prog start", 16'h3, {sbit, stall});
      done_wait;
      for (i = 0; i < 64; i = i + 1)
         chk("byte", (i % 3 == 0) ? 16'hff : i[7:0] ^ 8'hc3, u_fbs_flash_model.mem[i]);
      chk("prog bytes", 16'h40, u_fbs_flash_model.n_prog[15:0]);
      chk("written bytes", 16'h2a, u_fbs_flash_model.n_en[15:0]);
      go(8'h55, 8'haa, 1'b1);
      done_wait;
      chk("reprog bytes", 16'h2a, u_fbs_flash_model.n_en[15:0]);
      chk("reprog offers", 16'h80, u_fbs_flash_model.n_prog[15:0]);
      $display("test program done");
      go(8'h55, 8'haa, 1'b0);
      chk("no key", 16'h1, {sbit, abrt});
      @(posedge clk_sys);
      aclr <= 1'b1;
      @(posedge clk_sys);
      aclr <= 1'b0;
      #1;
      chk("abort clear", 16'h0, abrt);
      go(8'haa, 8'h55, 1'b1);
      chk("wrong order", 16'h1, {sbit, abrt});
      $display("test refusal done");
      @(posedge clk_sys);
      aclr <= 1'b1;
      @(posedge clk_sys);
      aclr <= 1'b0;
      go(8'h55, 8'haa, 1'b1);
      chk("start after clear", 16'h2, {sbit, abrt});
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      #1;
      chk("reset abort", 16'hc, {sbit, abrt, psel, csel, wal});
      $display("test reset done");
      conclude;
   end
   task tw(input [21:0] p, input [7:0] d);
      begin
         @(posedge clk_sys);
         twr <= 1'b1;
         ptr <= p;
         lat <= d;
         @(posedge clk_sys);
         twr <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire
